// ---- rtl/caf_pkg.sv ----
// consequent action filter: shared constants, register map and field layout
// assumes a single 125 MHz clock domain and a 32-bit AXI4-Lite register bus
package caf_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    // traffic word carried through each role
    localparam int TRAF_W = 8;
    localparam logic [TRAF_W-1:0] AIS_PATTERN = {TRAF_W{1'b1}};
    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] INT_MASK_OFS = 8'h0c;
    // control fields
    localparam int CTRL_LOA_LSB = 0;
    localparam int CTRL_LOA_W = 2;
    localparam int CTRL_HAS_AIS_BIT = 2;
    localparam int CTRL_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h4;
    // action bits, shared by status, interrupt status and mask
    localparam int ACT_TT_AIS = 0;
    localparam int ACT_SO_AIS = 1;
    localparam int ACT_SK_AIS = 2;
    localparam int ACT_SSF = 3;
    localparam int ACT_TSF = 4;
    localparam int N_ACT = 5;
    localparam int N_ROLE = 3;
    localparam logic [N_ACT-1:0] ACT_RST = 5'h00;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // source of the loss-of-alignment term
    typedef enum logic [CTRL_LOA_W-1:0] {
        LOA_FRAME = 2'b00,
        LOA_MULTI = 2'b01,
        LOA_POINTER = 2'b10
    } loa_src_t;
endpackage : caf_pkg

// ---- rtl/ais_replacer.sv ----
// one role's output stage: registers the alarm request and swaps traffic for all-ones
// assumes request and traffic come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module ais_replacer
    import caf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // request and traffic
    input wire logic req_d,
    input wire logic [TRAF_W-1:0] data_in,
    output logic req_q,
    output logic [TRAF_W-1:0] data_q
);
    // request and data share one register stage so they stay aligned
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_q <= 1'b0;
            data_q <= '0;
        end else if (ce) begin
            req_q <= req_d;
            data_q <= req_d ? AIS_PATTERN : data_in; // RL8
        end
    end
endmodule : ais_replacer
`default_nettype wire

// ---- rtl/consequent_action_filter.sv ----
// consequent action filter: defects in, alarm insertion and fail indications out
// assumes defect flags come from same-clock detectors, already persistence filtered
// Operation
// [RL1] trail sink alarm request equals incoming alarm or loss of signal
// [RL2] source alarm request follows the received server-fail input
// [RL3] sink alarm request is mismatch or alignment loss or alarm term or inactive
// [RL4] sink server-fail is mismatch or alarm term or alignment loss
// [RL5] trail sink trail-fail is server-fail input or loss of signal or trace mismatch
// [RL6] sink without own alarm detector uses trail-fail input as alarm term
// [RL7] alignment loss term comes from frame, multiframe or pointer defect
// [RL8] while alarm requested, traffic output is replaced with all ones
// [RL9] sink server-fail action is driven out to the downstream function
// [RL10] trail sink trail-fail action is driven out to downstream functions
// [RL11] upstream raises alarm defect after more than three frames of anomaly
// [RL12] frame loss defect comes from a three-in, five-out persistence machine
// [RL13] actions recomputed each cycle, no filtering, registered once
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module consequent_action_filter
    import caf_pkg::*;
(
    // clock, reset, freeze
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // defect flags from detectors
    input wire logic incoming_alarm_defect,
    input wire logic loss_of_signal_defect,
    input wire logic payload_mismatch_defect,
    input wire logic loss_of_frame_defect,
    input wire logic loss_of_multiframe_defect,
    input wire logic loss_of_pointer_defect,
    input wire logic trace_mismatch_defect,
    input wire logic not_active_flag,
    // fail indications from neighbouring functions
    input wire logic server_fail_input,
    input wire logic trail_fail_input,
    input wire logic src_server_fail_input,
    // traffic of the three roles
    input wire logic [TRAF_W-1:0] tt_data_in,
    input wire logic [TRAF_W-1:0] so_data_in,
    input wire logic [TRAF_W-1:0] sk_data_in,
    output logic [TRAF_W-1:0] tt_data_out,
    output logic [TRAF_W-1:0] so_data_out,
    output logic [TRAF_W-1:0] sk_data_out,
    // action outputs
    output logic tt_alarm_insert_request,
    output logic so_alarm_insert_request,
    output logic sk_alarm_insert_request,
    output logic server_fail_action,
    output logic trail_fail_action,
    // interrupt
    output logic irq,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    // register map decode, shared by the write and read paths
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == CTRL_OFS) || (a == STATUS_OFS) ||
            (a == INT_STATUS_OFS) || (a == INT_MASK_OFS);
    endfunction : addr_mapped

    // byte-lane merge of a write into a register word
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] nw, input logic [STRB_W-1:0] st);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < STRB_W; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    logic [CTRL_W-1:0] ctrl_q;
    logic [N_ACT-1:0] act_d;
    logic [N_ACT-1:0] act_q;
    logic [N_ACT-1:0] int_status_q;
    logic [N_ACT-1:0] int_mask_q;
    logic [N_ACT-1:0] int_clr;
    logic loa_term;
    logic alarm_term;
    logic [ADDR_W-1:0] aw_addr_q;
    logic aw_have_q;
    logic [DATA_W-1:0] w_data_q;
    logic [STRB_W-1:0] w_strb_q;
    logic w_have_q;
    logic wr_fire;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] mask_word;
    logic [DATA_W-1:0] clr_word;

    // alarm and alignment terms chosen per the instance configuration
    always_comb begin
        case (loa_src_t'(ctrl_q[CTRL_LOA_LSB +: CTRL_LOA_W]))
            LOA_FRAME: loa_term = loss_of_frame_defect; // RL7
            LOA_MULTI: loa_term = loss_of_multiframe_defect; // RL7
            LOA_POINTER: loa_term = loss_of_pointer_defect; // RL7
            default: loa_term = loss_of_frame_defect;
        endcase
        // without an own detector, the trail-fail input stands in for it
        alarm_term = ctrl_q[CTRL_HAS_AIS_BIT] ? incoming_alarm_defect
            : trail_fail_input; // RL6
    end

    // actions are pure functions of this cycle's inputs, no persistence here
    always_comb begin
        act_d = '0;
        act_d[ACT_TT_AIS] = incoming_alarm_defect | loss_of_signal_defect; // RL1
        act_d[ACT_SO_AIS] = src_server_fail_input; // RL2
        act_d[ACT_SK_AIS] = payload_mismatch_defect | loa_term | alarm_term
            | not_active_flag; // RL3
        act_d[ACT_SSF] = payload_mismatch_defect | alarm_term | loa_term; // RL4
        act_d[ACT_TSF] = server_fail_input | loss_of_signal_defect
            | trace_mismatch_defect; // RL5
    end

    // fail indications registered once, straight to the ports
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            server_fail_action <= 1'b0;
            trail_fail_action <= 1'b0;
        end else if (ce) begin
            server_fail_action <= act_d[ACT_SSF]; // RL9 RL13
            trail_fail_action <= act_d[ACT_TSF]; // RL10 RL13
        end
    end

    // one output stage per role; request and traffic stay cycle-aligned
    logic [TRAF_W-1:0] role_in [N_ROLE];
    logic [TRAF_W-1:0] role_out [N_ROLE];
    logic [N_ROLE-1:0] role_req_d;
    logic [N_ROLE-1:0] role_req_q;
    assign role_in[ACT_TT_AIS] = tt_data_in;
    assign role_in[ACT_SO_AIS] = so_data_in;
    assign role_in[ACT_SK_AIS] = sk_data_in;
    assign role_req_d = act_d[N_ROLE-1:0];
    generate
        for (genvar g = 0; g < N_ROLE; g++) begin : g_role
            ais_replacer u_rep (
                .clk(core_clk),
                .rst(rst),
                .ce(ce),
                .req_d(role_req_d[g]),
                .data_in(role_in[g]),
                .req_q(role_req_q[g]),
                .data_q(role_out[g])
            );
        end
    endgenerate
    assign tt_data_out = role_out[ACT_TT_AIS];
    assign so_data_out = role_out[ACT_SO_AIS];
    assign sk_data_out = role_out[ACT_SK_AIS];
    assign tt_alarm_insert_request = role_req_q[ACT_TT_AIS];
    assign so_alarm_insert_request = role_req_q[ACT_SO_AIS];
    assign sk_alarm_insert_request = role_req_q[ACT_SK_AIS];
    assign act_q = {trail_fail_action, server_fail_action, role_req_q};

    // write channel capture: address and data may arrive in either order
    assign wr_fire = aw_have_q && w_have_q && !bvalid;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
                aw_have_q <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
                w_have_q <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= addr_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            // reopen both channels only once the response is taken
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // register writes; status is read only and the write is silently ignored
    assign ctrl_word = merge({{(DATA_W-CTRL_W){1'b0}}, ctrl_q}, w_data_q, w_strb_q);
    assign mask_word = merge({{(DATA_W-N_ACT){1'b0}}, int_mask_q}, w_data_q, w_strb_q);
    assign clr_word = merge('0, w_data_q, w_strb_q);
    assign int_clr = (wr_fire && aw_addr_q == INT_STATUS_OFS) ? clr_word[N_ACT-1:0] : '0;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            int_mask_q <= ACT_RST;
        end else if (ce && wr_fire) begin
            if (aw_addr_q == CTRL_OFS) begin
                ctrl_q <= ctrl_word[CTRL_W-1:0];
            end else if (aw_addr_q == INT_MASK_OFS) begin
                int_mask_q <= mask_word[N_ACT-1:0];
            end
        end
    end

    // sticky rising-edge events; a new event beats a same-cycle clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_status_q <= ACT_RST;
            irq <= 1'b0;
        end else if (ce) begin
            int_status_q <= (int_status_q & ~int_clr) | (act_d & ~act_q);
            irq <= |(((int_status_q & ~int_clr) | (act_d & ~act_q)) & int_mask_q);
        end
    end

    // read channel: one read under way, arready drops until rdata is taken
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
                rdata <= '0;
                if (araddr == CTRL_OFS) begin
                    rdata <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
                end else if (araddr == STATUS_OFS) begin
                    rdata <= {{(DATA_W-N_ACT){1'b0}}, act_q};
                end else if (araddr == INT_STATUS_OFS) begin
                    rdata <= {{(DATA_W-N_ACT){1'b0}}, int_status_q};
                end else if (araddr == INT_MASK_OFS) begin
                    rdata <= {{(DATA_W-N_ACT){1'b0}}, int_mask_q};
                end
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // checks
    // judging starts one edge after reset leaves; the release edge still ran the reset branch
    logic live_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            live_q <= 1'b0;
        end else if (ce) begin
            live_q <= 1'b1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst || !live_q);

    property p_tt_alarm;
        ce |=> tt_alarm_insert_request == $past(incoming_alarm_defect | loss_of_signal_defect);
    endproperty
    a_tt_alarm: assert property (p_tt_alarm) else $error("tt alarm request wrong"); // RL1

    property p_so_alarm;
        ce |=> so_alarm_insert_request == $past(src_server_fail_input);
    endproperty
    a_so_alarm: assert property (p_so_alarm) else $error("source alarm request wrong"); // RL2

    property p_sk_alarm;
        ce |=> sk_alarm_insert_request == $past(payload_mismatch_defect | not_active_flag
            | loa_term | alarm_term);
    endproperty
    a_sk_alarm: assert property (p_sk_alarm) else $error("sink alarm request wrong"); // RL3

    property p_ssf;
        ce |=> server_fail_action == $past(payload_mismatch_defect | alarm_term | loa_term);
    endproperty
    a_ssf: assert property (p_ssf) else $error("server fail action wrong"); // RL4

    property p_tsf;
        ce |=> trail_fail_action == $past(server_fail_input | loss_of_signal_defect
            | trace_mismatch_defect);
    endproperty
    a_tsf: assert property (p_tsf) else $error("trail fail action wrong"); // RL5

    property p_no_detector;
        (ce && !ctrl_q[CTRL_HAS_AIS_BIT] && trail_fail_input) |=> server_fail_action;
    endproperty
    a_no_detector: assert property (p_no_detector) else $error("trail fail ignored"); // RL6

    property p_loa_pointer;
        (ce && ctrl_q[CTRL_LOA_LSB +: CTRL_LOA_W] == LOA_POINTER && loss_of_pointer_defect)
            |=> server_fail_action && sk_alarm_insert_request;
    endproperty
    a_loa_pointer: assert property (p_loa_pointer) else $error("pointer loss ignored"); // RL7

    property p_ais_data;
        sk_alarm_insert_request |-> sk_data_out == AIS_PATTERN;
    endproperty
    a_ais_data: assert property (p_ais_data) else $error("sink traffic not all ones"); // RL8

    property p_clean_pass;
        (ce && !act_d[ACT_TT_AIS]) |=> tt_data_out == $past(tt_data_in);
    endproperty
    a_clean_pass: assert property (p_clean_pass) else $error("tt traffic altered"); // RL8

    sequence s_inputs_hold;
        ce ##1 (ce && $stable(act_d));
    endsequence
    property p_settled;
        s_inputs_hold |=> act_q == $past(act_d, 2);
    endproperty
    a_settled: assert property (p_settled) else $error("action not settled"); // RL9 RL10 RL13

    sequence s_write_done;
        wr_fire ##1 bvalid;
    endsequence
    property p_write_resp;
        (wr_fire && ce) |-> s_write_done;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response late");
endmodule : consequent_action_filter
`default_nettype wire

// ---- tb/caf_defect_source.sv ----
// partner model: upstream detectors that filter anomalies into the alarm and frame defects
// assumes every core_clk edge is one frame opportunity, so both counts are in cycles
`timescale 1ns/1ps
`default_nettype none
module caf_defect_source (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // raw anomalies
    input wire logic incoming_alarm_anomaly,
    input wire logic frame_loss_anomaly,
    // filtered defects
    output logic incoming_alarm_defect,
    output logic loss_of_frame_defect
);
    logic [2:0] alarm_cnt_q;
    logic [2:0] frame_cnt_q;
    // alarm defect only after more than three consecutive anomalous frames
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            alarm_cnt_q <= 3'h0;
            incoming_alarm_defect <= 1'b0;
        end else begin
            // count saturates once the threshold is passed
            if (!incoming_alarm_anomaly) begin
                alarm_cnt_q <= 3'h0;
            end else if (alarm_cnt_q != 3'h4) begin
                alarm_cnt_q <= alarm_cnt_q + 3'h1;
            end
            incoming_alarm_defect <= incoming_alarm_anomaly && (alarm_cnt_q >= 3'h3);
        end
    end
    // out-of-frame after reset; three clean to enter frame, five bad to leave it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frame_cnt_q <= 3'h0;
            loss_of_frame_defect <= 1'b1;
        end else if (loss_of_frame_defect == frame_loss_anomaly) begin
            frame_cnt_q <= 3'h0;
        end else if (frame_cnt_q == (loss_of_frame_defect ? 3'h2 : 3'h4)) begin
            frame_cnt_q <= 3'h0;
            loss_of_frame_defect <= ~loss_of_frame_defect;
        end else begin
            frame_cnt_q <= frame_cnt_q + 3'h1;
        end
    end
endmodule : caf_defect_source
`default_nettype wire

// ---- tb/consequent_action_filter_bench.sv ----
// self-checking bench: defect combinations, alignment source, latency, freeze and interrupts
// assumes the partner model sits between the bench's anomalies and the alarm and frame defects
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %0t got %h want %h", $time, (got), (exp)); end end
module consequent_action_filter_bench;
    import caf_pkg::*;
    logic core_clk = 0, rst = 1, ce = 1;
    logic incoming_alarm_anomaly = 0, frame_loss_anomaly = 0, loss_of_signal_defect = 0;
    logic payload_mismatch_defect = 0, loss_of_multiframe_defect = 0, loss_of_pointer_defect = 0;
    logic trace_mismatch_defect = 0, not_active_flag = 0, server_fail_input = 0;
    logic trail_fail_input = 0, src_server_fail_input = 0;
    logic incoming_alarm_defect, loss_of_frame_defect;
    logic [TRAF_W-1:0] tt_data_in = 0, so_data_in = 0, sk_data_in = 0;
    logic [TRAF_W-1:0] tt_data_out, so_data_out, sk_data_out;
    logic tt_alarm_insert_request, so_alarm_insert_request, sk_alarm_insert_request;
    logic server_fail_action, trail_fail_action, irq;
    logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
    logic [DATA_W-1:0] wdata = 0, rdata;
    logic [STRB_W-1:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [DATA_W-1:0] rd;
    int errors = 0, comparisons = 0;
    caf_defect_source partner (.core_clk, .rst, .incoming_alarm_anomaly, .frame_loss_anomaly,
        .incoming_alarm_defect, .loss_of_frame_defect);
    consequent_action_filter uut (.core_clk, .rst, .ce, .incoming_alarm_defect,
        .loss_of_signal_defect, .payload_mismatch_defect, .loss_of_frame_defect,
        .loss_of_multiframe_defect, .loss_of_pointer_defect, .trace_mismatch_defect,
        .not_active_flag, .server_fail_input, .trail_fail_input, .src_server_fail_input,
        .tt_data_in, .so_data_in, .sk_data_in, .tt_data_out, .so_data_out, .sk_data_out,
        .tt_alarm_insert_request, .so_alarm_insert_request, .sk_alarm_insert_request,
        .server_fail_action, .trail_fail_action, .irq, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);
    // 125 MHz core clock
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // write with address and data offered together; checks the response code
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                             input logic [1:0] er);
        logic aw_done, w_done;
        int n;
        aw_done = 0;
        w_done = 0;
        n = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_done && w_done) && n < 100) begin
            @(posedge core_clk);
            n++;
            if (!aw_done && awready === 1'b1) begin aw_done = 1; awvalid <= 0; end
            if (!w_done && wready === 1'b1) begin w_done = 1; wvalid <= 0; end
        end
        do begin @(posedge core_clk); n++; end while (bvalid !== 1'b1 && n < 200);
        bready <= 0;
        `CHK(bresp, er)
    endtask : axi_write
    // read one word; result left in rd, response code checked
    task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin @(posedge core_clk); n++; end while (arready !== 1'b1 && n < 100);
        arvalid <= 0;
        do begin @(posedge core_clk); n++; end while (rvalid !== 1'b1 && n < 200);
        rd = rdata;
        rready <= 0;
        `CHK(rresp, er)
    endtask : axi_read
    // compare every action and traffic output against the current, settled inputs
    task automatic check_actions(input logic [2:0] c);
        logic loa, at, tt, so, sk, tsf;
        loa = (c[1:0] == 2'h1) ? loss_of_multiframe_defect :
              (c[1:0] == 2'h2) ? loss_of_pointer_defect : loss_of_frame_defect;
        at = c[CTRL_HAS_AIS_BIT] ? incoming_alarm_defect : trail_fail_input;
        tt = incoming_alarm_defect | loss_of_signal_defect;
        so = src_server_fail_input;
        sk = payload_mismatch_defect | loa | at | not_active_flag;
        tsf = server_fail_input | loss_of_signal_defect | trace_mismatch_defect;
        `CHK(tt_alarm_insert_request, tt)
        `CHK(so_alarm_insert_request, so)
        `CHK(sk_alarm_insert_request, sk)
        `CHK(server_fail_action, payload_mismatch_defect | at | loa)
        `CHK(trail_fail_action, tsf)
        `CHK(tt_data_out, tt ? AIS_PATTERN : tt_data_in)
        `CHK(so_data_out, so ? AIS_PATTERN : so_data_in)
        `CHK(sk_data_out, sk ? AIS_PATTERN : sk_data_in)
    endtask : check_actions
    // reset values of the control, status and mask registers and a refused read
    task automatic test_reset_map();
        axi_read(CTRL_OFS, RESP_OKAY);
        `CHK(rd[CTRL_W-1:0], CTRL_RST)
        axi_read(STATUS_OFS, RESP_OKAY);
        `CHK(rd[N_ACT-1:0], ACT_RST)
        axi_read(INT_MASK_OFS, RESP_OKAY);
        `CHK(rd[N_ACT-1:0], ACT_RST)
        axi_read(8'h40, RESP_SLVERR);
        `CHK(rd, 32'h0)
    endtask : test_reset_map
    // every input combination, with the alignment source and alarm term varied alongside
    task automatic test_combinations();
        logic [10:0] v;
        logic [2:0] c;
        for (int i = 0; i < 2048; i++) begin
            v = i[10:0];
            c = v[2:0] + v[10:8];
            axi_write(CTRL_OFS, {29'h0, c}, RESP_OKAY);
            {incoming_alarm_anomaly, loss_of_signal_defect, payload_mismatch_defect} <= v[2:0];
            {frame_loss_anomaly, loss_of_multiframe_defect, loss_of_pointer_defect} <= v[5:3];
            {trace_mismatch_defect, not_active_flag, server_fail_input} <= v[8:6];
            {trail_fail_input, src_server_fail_input} <= v[10:9];
            tt_data_in <= v[7:0]; so_data_in <= ~v[7:0]; sk_data_in <= v[10:3];
            repeat (9) @(posedge core_clk);
            #1 check_actions(c);
        end
    endtask : test_combinations
    // one cycle from input to output, and a low enable freezes the outputs
    task automatic test_latency_freeze();
        loss_of_signal_defect <= 1;
        #1 `CHK(tt_alarm_insert_request, 1'b0)
        @(posedge core_clk);
        #1 `CHK(tt_alarm_insert_request, 1'b1)
        `CHK(trail_fail_action, 1'b1)
        @(posedge core_clk);
        ce <= 0; loss_of_signal_defect <= 0;
        repeat (3) @(posedge core_clk);
        #1 `CHK(tt_alarm_insert_request, 1'b1)
        ce <= 1;
        repeat (2) @(posedge core_clk);
        #1 `CHK(tt_alarm_insert_request, 1'b0)
    endtask : test_latency_freeze
    // sticky status, mask and write-one-to-clear on the interrupt line
    task automatic test_interrupts();
        axi_write(INT_STATUS_OFS, 32'h1f, RESP_OKAY);
        axi_read(INT_STATUS_OFS, RESP_OKAY);
        `CHK(rd[N_ACT-1:0], 5'h00)
        axi_write(INT_MASK_OFS, 32'h10, RESP_OKAY);
        loss_of_signal_defect <= 1;
        repeat (3) @(posedge core_clk);
        #1 `CHK(irq, 1'b1)
        axi_read(INT_STATUS_OFS, RESP_OKAY);
        `CHK(rd[N_ACT-1:0], 5'h11)
        axi_read(STATUS_OFS, RESP_OKAY);
        `CHK(rd[N_ACT-1:0], 5'h11)
        axi_write(STATUS_OFS, 32'h0, RESP_OKAY);
        axi_write(8'h40, 32'h7, RESP_SLVERR);
        axi_write(INT_MASK_OFS, 32'h0, RESP_OKAY);
        repeat (2) @(posedge core_clk);
        #1 `CHK(irq, 1'b0)
        axi_write(INT_MASK_OFS, 32'h11, RESP_OKAY);
        repeat (2) @(posedge core_clk);
        #1 `CHK(irq, 1'b1)
        axi_write(INT_STATUS_OFS, 32'h11, RESP_OKAY);
        repeat (2) @(posedge core_clk);
        #1 `CHK(irq, 1'b0)
        axi_read(CTRL_OFS, RESP_OKAY);
        `CHK(rd[CTRL_W-1:0], CTRL_RST)
    endtask : test_interrupts
    // verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    // the full run takes about 27k cycles; the limit is about 62k so a hang stays short
    initial begin
        #500us;
        errors++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 0;
        test_reset_map();
        test_combinations();
        axi_write(CTRL_OFS, {29'h0, CTRL_RST}, RESP_OKAY);
        @(posedge core_clk);
        {incoming_alarm_anomaly, loss_of_signal_defect, payload_mismatch_defect} <= 3'h0;
        {frame_loss_anomaly, loss_of_multiframe_defect, loss_of_pointer_defect} <= 3'h0;
        {trace_mismatch_defect, not_active_flag, server_fail_input} <= 3'h0;
        {trail_fail_input, src_server_fail_input} <= 2'h0;
        repeat (9) @(posedge core_clk);
        test_latency_freeze();
        test_interrupts();
        finish_test();
    end
endmodule : consequent_action_filter_bench
`default_nettype wire
